// ==== verilog/pto_panel_timing.sv ====
// Panel output timing control: configuration register and panel pin logic.
// ============================================================================
// Notes on behaviour
// - Ratio bit 0 runs memory clock at pixel rate; 1 at two-thirds.
// - Bypass bit routes incoming data and syncs straight to panel pins.
// - Strobe polarity and pin selects act only outside bypass mode.
// - Display strobe is active low when polarity bit is 0, else high.
// - For TFT, retrace gate picks active-only or whole-frame shift clock.
// - Line pin carries STN line pulse at 0, TFT horizontal sync at 1.
// - Frame pin carries STN first-line marker at 0, TFT vertical sync at 1.
// - Vertical output polarity inverts only for TFT with frame select set.
// - Incoming vertical sync polarity set by its own separate input bit.
// - Horizontal output polarity inverts only for TFT with line select set.
// - Incoming horizontal sync polarity set by its own separate input bit.
// - Panel type 00 is STN, 01 is TFT; 10 and 11 are reserved.
// - Panel type and output format decide data pin mapping; panel type also gates the shift clock.
// - Colour bit 0 treats panel as colour, 1 as monochrome.
// - Bit 28 is reserved; the logic ignores it and it reads zero.
// - Horizontal source 0 passes input sync; 1 generates it from positions.
// ============================================================================
`timescale 1ns/1ps
`default_nettype none
module pto_panel_timing (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        cfg_req_i,
  input  wire logic        cfg_we_i,
  input  wire logic [11:0] cfg_addr_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  input  wire logic        horiz_in_polarity_i,
  input  wire logic        vert_in_polarity_i,
  input  wire logic        horiz_out_source_sel_i,
  input  wire logic [2:0]  hsync_lead_pos_i,
  input  wire logic [4:0]  hsync_trail_pos_i,
  input  wire logic        pixel_clock_i,
  input  wire logic        horiz_sync_input_i,
  input  wire logic        vert_sync_input_i,
  input  wire logic        display_enable_in_i,
  input  wire logic [17:0] pixel_data_i,
  output logic             line_pin_o,
  output logic             frame_pin_o,
  output logic             display_enable_strobe_o,
  output logic             panel_shift_clock_o,
  output logic      [11:0] lower_panel_data_o,
  output logic      [11:0] upper_panel_data_o,
  output logic             mem_clk_en_o
);
  import pto_pkg::*;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Leading edge code 0 means no delay; codes 1 to 7 mean 2 to 8 clocks.
  function automatic logic [5:0] pto_lead_pos(input logic [2:0] code);
    pto_lead_pos = (code == 3'h0) ? 6'h00 : {3'h0, code} + 6'h01;
  endfunction : pto_lead_pos

  // Splits the 6:6:6 pixel over the lower and upper pins.
  function automatic logic [23:0] pto_map_pixel(input logic [1:0]  ptype,
                                                 input logic [2:0]  fmt,
                                                 input logic        mono,
                                                 input logic [17:0] pix);
    logic [17:0] v;
    v = pix;
    if (mono) begin
      v = {pix[11:6], pix[11:6], pix[11:6]};
    end
    if (ptype == PTO_TYPE_TFT) begin
      pto_map_pixel = {6'h00, v[17:12], v[11:0]};
    end else if (fmt == 3'h0) begin
      pto_map_pixel = {4'h0, v[17:14], v[11:8], 4'h0, v[5:2], 4'h0};
    end else begin
      pto_map_pixel = {6'h00, v};
    end
  endfunction : pto_map_pixel

  // ==========================================================================
  // Reference clock state
  // ==========================================================================
  typedef struct packed {
    logic [31:0] ctrl2;
    logic [31:0] rdata;
    logic [10:0] side_s1;
    logic [10:0] side_s2;
  } pto_ref_s;

  pto_ref_s r, next_r;
  pto_cfg_s ref_cfg;
  logic     hit;

  assign hit = (cfg_addr_i == PTO_CTRL2_OFS);

  always_comb begin
    next_r         = r;
    next_r.side_s1 = {horiz_in_polarity_i, vert_in_polarity_i, horiz_out_source_sel_i,
                      hsync_lead_pos_i, hsync_trail_pos_i};
    next_r.side_s2 = r.side_s1;
    if (cfg_req_i && cfg_we_i && hit) begin
      next_r.ctrl2 = cfg_wdata_i & ~PTO_CTRL2_RSVD;
    end
    if (cfg_req_i && !cfg_we_i) begin
      next_r.rdata = hit ? r.ctrl2 : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '{ctrl2: PTO_CTRL2_RST, rdata: 32'h0000_0000, side_s1: 11'h000, side_s2: 11'h000};
    end else begin
      r <= next_r;
    end
  end

  assign cfg_rdata_o = r.rdata;
  assign ref_cfg     = pto_decode(r.ctrl2, r.side_s2);

  // ==========================================================================
  // Crossing and memory clock
  // ==========================================================================
  pto_px_if px_bus ();

  pto_cfg_cdc u_cdc (
    .ref_clk_i     (ref_clk_i),
    .pixel_clock_i (pixel_clock_i),
    .rst_b_i       (rst_b_i),
    .word_i        (ref_cfg),
    .px            (px_bus.src)
  );

  pto_mclk_gen u_mclk (
    .pixel_clock_i (pixel_clock_i),
    .rst_b_i       (rst_b_i),
    .px            (px_bus.dst),
    .mem_clk_en_o  (mem_clk_en_o)
  );

  // ==========================================================================
  // Pixel clock state
  // ==========================================================================
  typedef struct packed {
    logic        h_prev;
    logic [5:0]  h_cnt;
    logic        h_gen;
    logic        line;
    logic        frame;
    logic        strobe;
    logic        shift;
    logic [11:0] lower;
    logic [11:0] upper;
  } pto_px_s;

  pto_px_s  p, next_p;
  pto_cfg_s c;
  logic     h_mod;
  logic     v_mod;
  logic     h_rise;
  logic     tft;
  logic     h_core;
  logic     pulse_ok;
  logic [5:0]  cur;
  logic [5:0]  lead;
  logic [23:0] mapped;

  assign c = px_bus.cfg;

  assign h_mod = horiz_sync_input_i ^ c.hin_pol;
  assign v_mod = vert_sync_input_i ^ c.vin_pol;
  assign tft   = (c.ptype == PTO_TYPE_TFT);

  assign h_rise   = h_mod & ~p.h_prev;
  assign cur      = h_rise ? 6'h00 : p.h_cnt;
  assign lead     = pto_lead_pos(c.hlead);
  assign pulse_ok = ({1'b0, c.htrail} > lead);
  assign mapped   = pto_map_pixel(c.ptype, c.fmt, c.mono, pixel_data_i);
  assign h_core   = c.hsrc ? p.h_gen : h_mod;

  always_comb begin
    next_p        = p;
    next_p.h_prev = h_mod;
    next_p.h_cnt  = (cur == PTO_HCNT_MAX) ? cur : cur + 6'h01;
    // generated edges
    // A pulse whose trailing edge is not after its leading edge is never
    // produced rather than produced with zero width.
    if (!pulse_ok) begin
      next_p.h_gen = 1'b0;
    end else if (cur == {1'b0, c.htrail}) begin
      next_p.h_gen = 1'b0;
    end else if (cur == lead) begin
      next_p.h_gen = 1'b1;
    end
    if (c.bypass) begin
      next_p.line   = horiz_sync_input_i;
      next_p.frame  = vert_sync_input_i;
      next_p.strobe = display_enable_in_i;
      next_p.shift  = ~p.shift;
      next_p.lower  = pixel_data_i[11:0];
      next_p.upper  = {6'h00, pixel_data_i[17:12]};
    end else begin
      next_p.line   = c.line_sel ? (h_core ^ (tft & c.hpol)) : h_mod;
      next_p.frame  = c.frame_sel ? (v_mod ^ (tft & c.vpol)) : v_mod;
      next_p.strobe = c.strobe_pol ? display_enable_in_i : ~display_enable_in_i;
      if ((tft && c.shift_gate) || display_enable_in_i) begin
        next_p.shift = ~p.shift;
      end else begin
        next_p.shift = 1'b0;
      end
      next_p.lower  = mapped[11:0];
      next_p.upper  = mapped[23:12];
    end
  end

  always_ff @(posedge pixel_clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      p <= '{h_prev: 1'b0, h_cnt: PTO_HCNT_RST, h_gen: 1'b0, line: 1'b0, frame: 1'b0,
             strobe: 1'b0, shift: 1'b0, lower: 12'h000, upper: 12'h000};
    end else begin
      p <= next_p;
    end
  end

  assign line_pin_o              = p.line;
  assign frame_pin_o             = p.frame;
  assign display_enable_strobe_o = p.strobe;
  assign panel_shift_clock_o     = p.shift;
  assign lower_panel_data_o      = p.lower;
  assign upper_panel_data_o      = p.upper;

endmodule : pto_panel_timing
`default_nettype wire

// ==== verilog/pto_pkg.sv ====
// Constants, field layout and types for the panel output timing control block.
package pto_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [11:0] PTO_CTRL2_OFS  = 12'h404;
  localparam logic [31:0] PTO_CTRL2_RST  = 32'h0000_0000;
  localparam logic [31:0] PTO_CTRL2_RSVD = 32'h1000_0000;

  // ==========================================================================
  // Field positions of panel_timing_control_2
  // ==========================================================================
  localparam int PTO_MCLK_BIT       = 31;
  localparam int PTO_BYPASS_BIT     = 30;
  localparam int PTO_STROBE_POL_BIT = 29;
  localparam int PTO_SHIFT_GATE_BIT = 27;
  localparam int PTO_LINE_SEL_BIT   = 26;
  localparam int PTO_STROBE_SEL_BIT = 25;
  localparam int PTO_FRAME_SEL_BIT  = 24;
  localparam int PTO_VPOL_BIT       = 23;
  localparam int PTO_HPOL_BIT       = 22;
  localparam int PTO_TYPE_LSB       = 20;
  localparam int PTO_MONO_BIT       = 19;
  localparam int PTO_FMT_LSB        = 16;

  // ==========================================================================
  // Encodings and widths
  // ==========================================================================
  localparam logic [1:0] PTO_TYPE_STN     = 2'h0;
  localparam logic [1:0] PTO_TYPE_TFT     = 2'h1;
  localparam int         PTO_PIX_W        = 18;
  localparam int         PTO_PANEL_W      = 12;
  localparam logic [1:0] PTO_MCLK_LAST    = 2'h2;
  localparam logic [1:0] PTO_MCLK_IDLE    = 2'h2;
  localparam logic [5:0] PTO_HCNT_MAX     = 6'h3f;
  localparam logic [5:0] PTO_HCNT_RST     = 6'h3f;

  // Configuration as seen by the pixel clock domain.
  typedef struct packed {
    logic       mclk_ratio;
    logic       bypass;
    logic       strobe_pol;
    logic       shift_gate;
    logic       line_sel;
    logic       strobe_sel;
    logic       frame_sel;
    logic       vpol;
    logic       hpol;
    logic [1:0] ptype;
    logic       mono;
    logic [2:0] fmt;
    logic       hin_pol;
    logic       vin_pol;
    logic       hsrc;
    logic [2:0] hlead;
    logic [4:0] htrail;
  } pto_cfg_s;

  localparam pto_cfg_s PTO_CFG_RST = '0;

  // Unpacks the register word and the side pins into one configuration.
  function automatic pto_cfg_s pto_decode(input logic [31:0] r, input logic [10:0] side);
    pto_cfg_s c;
    c            = PTO_CFG_RST;
    c.mclk_ratio = r[PTO_MCLK_BIT];
    c.bypass     = r[PTO_BYPASS_BIT];
    c.strobe_pol = r[PTO_STROBE_POL_BIT];
    c.shift_gate = r[PTO_SHIFT_GATE_BIT];
    c.line_sel   = r[PTO_LINE_SEL_BIT];
    c.strobe_sel = r[PTO_STROBE_SEL_BIT];
    c.frame_sel  = r[PTO_FRAME_SEL_BIT];
    c.vpol       = r[PTO_VPOL_BIT];
    c.hpol       = r[PTO_HPOL_BIT];
    c.ptype      = r[PTO_TYPE_LSB+:2];
    c.mono       = r[PTO_MONO_BIT];
    c.fmt        = r[PTO_FMT_LSB+:3];
    c.hin_pol    = side[10];
    c.vin_pol    = side[9];
    c.hsrc       = side[8];
    c.hlead      = side[7:5];
    c.htrail     = side[4:0];
    return c;
  endfunction : pto_decode

endpackage : pto_pkg

// ==== verilog/pto_px_if.sv ====
// Carries the crossed configuration inside the pixel clock domain.
`timescale 1ns/1ps
`default_nettype none
interface pto_px_if;
  import pto_pkg::*;
  pto_cfg_s cfg;
  logic     cfg_valid;
  modport src (output cfg, output cfg_valid);
  modport dst (input cfg, input cfg_valid);
endinterface : pto_px_if
`default_nettype wire

// ==== verilog/pto_cfg_cdc.sv ====
// Toggle handshake that carries the configuration word into the pixel domain.
`timescale 1ns/1ps
`default_nettype none
module pto_cfg_cdc (
  input  wire logic              ref_clk_i,
  input  wire logic              pixel_clock_i,
  input  wire logic              rst_b_i,
  input  wire pto_pkg::pto_cfg_s word_i,
  pto_px_if.src                  px
);
  import pto_pkg::*;

  typedef struct packed {
    logic     req;
    logic     ack_s1;
    logic     ack_s2;
    pto_cfg_s hold;
  } pto_cref_s;

  typedef struct packed {
    logic     req_s1;
    logic     req_s2;
    logic     req_s3;
    pto_cfg_s cfg;
    logic     valid;
  } pto_cpx_s;

  pto_cref_s r, next_r;
  pto_cpx_s  p, next_p;

  // ==========================================================================
  // Reference side
  // ==========================================================================
  // The held word changes only while no transfer is in flight, so the pixel
  // side always samples a settled value.
  always_comb begin
    next_r        = r;
    next_r.ack_s1 = p.req_s3;
    next_r.ack_s2 = r.ack_s1;
    if ((r.req == r.ack_s2) && (word_i != r.hold)) begin
      next_r.hold = word_i;
      next_r.req  = ~r.req;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '{req: 1'b0, ack_s1: 1'b0, ack_s2: 1'b0, hold: PTO_CFG_RST};
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Pixel side
  // ==========================================================================
  always_comb begin
    next_p        = p;
    next_p.req_s1 = r.req;
    next_p.req_s2 = p.req_s1;
    next_p.req_s3 = p.req_s2;
    next_p.valid  = 1'b0;
    if (p.req_s2 != p.req_s3) begin
      next_p.cfg   = r.hold;
      next_p.valid = 1'b1;
    end
  end

  always_ff @(posedge pixel_clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      p <= '{req_s1: 1'b0, req_s2: 1'b0, req_s3: 1'b0, cfg: PTO_CFG_RST, valid: 1'b0};
    end else begin
      p <= next_p;
    end
  end

  assign px.cfg       = p.cfg;
  assign px.cfg_valid = p.valid;

endmodule : pto_cfg_cdc
`default_nettype wire

// ==== verilog/pto_mclk_gen.sv ====
// Memory clock enable at the full or two-thirds pixel clock rate.
`timescale 1ns/1ps
`default_nettype none
module pto_mclk_gen (
  input  wire logic pixel_clock_i,
  input  wire logic rst_b_i,
  pto_px_if.dst     px,
  output logic      mem_clk_en_o
);
  import pto_pkg::*;

  typedef struct packed {
    logic [1:0] phase;
    logic       en;
  } pto_mclk_s;

  pto_mclk_s s, next_s;

  // ==========================================================================
  // Ratio pattern
  // ==========================================================================
  // ratio select
  // Two enables in every three pixel clocks give the two-thirds rate; the
  // enables are uneven in spacing, which the memory side must tolerate.
  always_comb begin
    next_s       = s;
    next_s.phase = (s.phase == PTO_MCLK_LAST) ? 2'h0 : s.phase + 2'h1;
    next_s.en    = px.cfg.mclk_ratio ? (next_s.phase != PTO_MCLK_IDLE) : 1'b1;
  end

  always_ff @(posedge pixel_clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '{phase: 2'h0, en: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign mem_clk_en_o = s.en;

endmodule : pto_mclk_gen
`default_nettype wire

// ==== dv/pto_panel_model.sv ====
// Panel-side model that counts the pixel cycles in which the line pin is high.
`timescale 1ns/1ps
`default_nettype none
module pto_panel_model (
  input  wire logic        pixel_clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        line_pin_i,
  output logic      [15:0] high_cycles_o
);
  // ====================
  // Line pulse sampling
  // ====================
  // The panel only listens, so a running total is enough; the bench takes differences.
  always_ff @(posedge pixel_clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      high_cycles_o <= 16'h0000;
    end else if (line_pin_i) begin
      high_cycles_o <= high_cycles_o + 16'h0001;
    end
  end
endmodule : pto_panel_model
`default_nettype wire

// ==== dv/pto_panel_timing_assertions.sv ====
// Concurrent checks on the ports of the panel output timing control block.
`timescale 1ns/1ps
`default_nettype none
module pto_panel_timing_chk (
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic        cfg_req_i,
  input wire logic        cfg_we_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        horiz_in_polarity_i,
  input wire logic        vert_in_polarity_i,
  input wire logic        horiz_out_source_sel_i,
  input wire logic        pixel_clock_i,
  input wire logic        horiz_sync_input_i,
  input wire logic        vert_sync_input_i,
  input wire logic        display_enable_in_i,
  input wire logic [17:0] pixel_data_i,
  input wire logic        line_pin_o,
  input wire logic        frame_pin_o,
  input wire logic        display_enable_strobe_o,
  input wire logic        panel_shift_clock_o,
  input wire logic [11:0] lower_panel_data_o,
  input wire logic [11:0] upper_panel_data_o,
  input wire logic        mem_clk_en_o
);
  // ====================
  // Shadow configuration
  // ====================
  // Pixel checks wait until the setup has been still for 15 register clocks, which
  // covers the crossing; the price is that transients after a change go unchecked.
  logic [31:0] sh;
  logic [2:0]  pins;
  logic [3:0]  stab;
  wire logic       wr   = cfg_req_i && cfg_we_i && cfg_addr_i == 12'h404;
  wire logic [2:0] pnow = {horiz_in_polarity_i, vert_in_polarity_i, horiz_out_source_sel_i};
  wire logic       ok   = stab == 4'hf;
  wire logic       tft  = sh[21:20] == 2'h1;
  wire logic       norm = ok && !sh[30];
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sh   <= 32'h0000_0000;
      pins <= 3'h0;
      stab <= 4'h0;
    end else begin
      sh   <= wr ? (cfg_wdata_i & ~32'h1000_0000) : sh;
      pins <= pnow;
      stab <= (wr || pins != pnow) ? 4'h0 : (ok ? stab : stab + 4'h1);
    end
  end
  // ====================
  // Properties
  // ====================
  // read back, bit 28 dropped
  AST_RD_MAPPED: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cfg_req_i && !cfg_we_i && cfg_addr_i == 12'h404 |=> cfg_rdata_o == $past(sh))
    else $error("read data differs from stored word");
  AST_MCLK_FULL: assert property (@(posedge pixel_clock_i) disable iff (!rst_b_i)
    ok && !sh[31] |-> mem_clk_en_o) else $error("memory clock enable dropped at full rate");
  AST_MCLK_TWO_THIRDS: assert property (@(posedge pixel_clock_i) disable iff (!rst_b_i)
    ok && sh[31] && !mem_clk_en_o |=> mem_clk_en_o [*2] ##1 !mem_clk_en_o)
    else $error("memory clock enable not two of three");
  AST_STROBE_POL: assert property (@(posedge pixel_clock_i) disable iff (!rst_b_i)
    norm |-> display_enable_strobe_o == ($past(display_enable_in_i) ~^ sh[29]))
    else $error("display strobe level wrong");
  AST_BYPASS: assert property (@(posedge pixel_clock_i) disable iff (!rst_b_i)
    ok && sh[30] |-> display_enable_strobe_o == $past(display_enable_in_i)
      && frame_pin_o == $past(vert_sync_input_i)
      && lower_panel_data_o == $past(pixel_data_i[11:0])) else $error("bypass path wrong");
  AST_SHIFT_GATED: assert property (@(posedge pixel_clock_i) disable iff (!rst_b_i)
    norm && !(tft && sh[27]) && !$past(display_enable_in_i) |-> !panel_shift_clock_o)
    else $error("shift clock active in retrace");
  AST_SHIFT_FREE: assert property (@(posedge pixel_clock_i) disable iff (!rst_b_i)
    norm && tft && sh[27] |-> ##1 panel_shift_clock_o != $past(panel_shift_clock_o))
    else $error("shift clock stopped");
  AST_LINE_PIN: assert property (@(posedge pixel_clock_i) disable iff (!rst_b_i)
    norm && !(sh[26] && pins[0]) |-> line_pin_o ==
      ($past(horiz_sync_input_i) ^ pins[2] ^ (tft && sh[26] && sh[22])))
    else $error("line pin level wrong");
  AST_FRAME_PIN: assert property (@(posedge pixel_clock_i) disable iff (!rst_b_i)
    norm |-> frame_pin_o == ($past(vert_sync_input_i) ^ pins[1] ^ (tft && sh[24] && sh[23])))
    else $error("frame pin level wrong");
  AST_TFT_DATA: assert property (@(posedge pixel_clock_i) disable iff (!rst_b_i)
    norm && tft |-> lower_panel_data_o == (sh[19] ? {2{$past(pixel_data_i[11:6])}}
      : $past(pixel_data_i[11:0])) && upper_panel_data_o == {6'h00, sh[19] ?
      $past(pixel_data_i[11:6]) : $past(pixel_data_i[17:12])}) else $error("TFT data wrong");
  AST_STN_DATA: assert property (@(posedge pixel_clock_i) disable iff (!rst_b_i)
    norm && !tft && sh[19:16] == 4'h0 |-> upper_panel_data_o == {4'h0,
      $past(pixel_data_i[17:14]), $past(pixel_data_i[11:8])} && lower_panel_data_o ==
      {4'h0, $past(pixel_data_i[5:2]), 4'h0}) else $error("STN data wrong");
endmodule : pto_panel_timing_chk
bind pto_panel_timing pto_panel_timing_chk u_chk (.*);
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking testbench for the panel output timing control block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pto_pkg::*;
  logic        ref_clk_i, rst_b_i, req, we, pixel_clock_i, hin_pol, vin_pol, hsrc;
  logic        hs, vs, de, line_o, frame_o, strobe_o, shift_o, mclk_o, man, man_h;
  logic [11:0] addr, lower_o, upper_o;
  logic [31:0] wdata, rdata, w;
  logic [2:0]  lead;
  logic [4:0]  trail;
  logic [17:0] pix;
  logic [15:0] high_cycles, h0;
  logic [2:0]  lt [3] = '{3'h1, 3'h3, 3'h7};
  logic [4:0]  tt [3] = '{5'h05, 5'h02, 5'h14};
  integer      seed = 22357;
  int          n_mismatch, total_checks, n;

  pto_panel_timing DUT (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .cfg_req_i(req),
    .cfg_we_i(we), .cfg_addr_i(addr), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata),
    .horiz_in_polarity_i(hin_pol), .vert_in_polarity_i(vin_pol),
    .horiz_out_source_sel_i(hsrc), .hsync_lead_pos_i(lead), .hsync_trail_pos_i(trail),
    .pixel_clock_i(pixel_clock_i), .horiz_sync_input_i(hs), .vert_sync_input_i(vs),
    .display_enable_in_i(de), .pixel_data_i(pix), .line_pin_o(line_o),
    .frame_pin_o(frame_o), .display_enable_strobe_o(strobe_o),
    .panel_shift_clock_o(shift_o), .lower_panel_data_o(lower_o),
    .upper_panel_data_o(upper_o), .mem_clk_en_o(mclk_o));
  pto_panel_model u_panel (.pixel_clock_i(pixel_clock_i), .rst_b_i(rst_b_i),
    .line_pin_i(line_o), .high_cycles_o(high_cycles));

  // ====================
  // Clocks and pixel stream
  // ====================
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    pixel_clock_i = 1'b0;
    #3.3;
    forever #7.5 pixel_clock_i = ~pixel_clock_i;
  end
  always @(posedge pixel_clock_i) begin
    pix <= 18'($random(seed));
    de  <= 1'($random(seed));
    vs  <= 1'($random(seed));
    hs  <= man ? man_h : 1'($random(seed));
  end

  // ====================
  // Tasks and expectations
  // ====================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    req   <= 1'b1;
    we    <= wr;
    addr  <= a;
    wdata <= d;
    @(posedge ref_clk_i);
    req   <= 1'b0;
  endtask : acc
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0000_0000);
    @(negedge ref_clk_i);
    // Bit 28 never reads back
    check(rdata, exp);
  endtask : rd
  task automatic cfg(input logic [31:0] word);
    acc(1'b1, 12'h404, word);
    rd(12'h404, word & ~PTO_CTRL2_RSVD);
    repeat (20) @(posedge ref_clk_i);
  endtask : cfg
  function automatic int exp_mclk(input logic ratio);
    return ratio ? 20 : 30;
  endfunction : exp_mclk
  function automatic int exp_width(input logic [2:0] ld, input logic [4:0] tr);
    int pos;
    pos = (ld == 3'h0) ? 0 : int'(ld) + 1;
    return (int'(tr) > pos) ? int'(tr) - pos : 0;
  endfunction : exp_width
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // ====================
  // Main sequence
  // ====================
  initial begin
    {req, we, man, man_h, hin_pol, vin_pol, hsrc, hs, vs, de} = '0;
    {addr, wdata, lead, trail, pix} = '0;
    n_mismatch = 0;
    total_checks = 0;
    rst_b_i = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    // strobe polarity resets to zero with the word
    rd(12'h404, PTO_CTRL2_RST);
    acc(1'b1, 12'h404, 32'h1200_0000);
    rd(12'h404, 32'h0200_0000);
    acc(1'b1, 12'h408, 32'hffff_ffff);
    rd(12'h404, 32'h0200_0000);
    rd(12'h400, 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      w = $random(seed);
      // software keeps strobe select set and bit 28 clear
      w[25] = 1'b1;
      w[28] = 1'b0;
      // ratio bit left random; the bench models no panel size.
      if (i[0]) w[19:16] = 4'h0;
      if (i % 3 == 0) w[30:20] = {1'b0, w[29:22], 2'h1};
      @(posedge ref_clk_i);
      hin_pol <= 1'($random(seed));
      vin_pol <= 1'($random(seed));
      cfg(w);
      n = 0;
      repeat (30) begin
        @(posedge pixel_clock_i);
        #1 n += int'(mclk_o === 1'b1);
      end
      check(32'(n), 32'(exp_mclk(w[31])));
      repeat (30) @(posedge ref_clk_i);
    end
    // Generated horizontal sync: the pulse width follows the edge positions.
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk_i);
      lead    <= lt[k];
      trail   <= tt[k];
      hsrc    <= 1'b1;
      man     <= 1'b1;
      hin_pol <= 1'b0;
      cfg(32'h0610_0000);
      h0 = high_cycles;
      @(posedge pixel_clock_i);
      man_h <= 1'b1;
      repeat (2) @(posedge pixel_clock_i);
      man_h <= 1'b0;
      repeat (60) @(posedge pixel_clock_i);
      check(32'(high_cycles - h0), 32'(exp_width(lt[k], tt[k])));
    end
    tally_and_finish();
  end
  initial begin
    #1000000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
